// *** ast_pkg.sv ***
// constants for the asynchronous serial transceiver: map, fields, timing
// assumes a 32-bit classic wishbone slave with byte addresses on an 8-bit bus
package ast_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_GIC   = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_ENAB  = 8'h08;
  localparam logic [7:0] OFS_PRIO  = 8'h0c;
  localparam logic [7:0] OFS_RCS   = 8'h10;
  localparam logic [7:0] OFS_THB   = 8'h14;
  localparam logic [7:0] OFS_TXS   = 8'h18;
  localparam logic [7:0] OFS_BLC   = 8'h1c;
  localparam logic [7:0] OFS_DIVH  = 8'h20;
  localparam logic [7:0] OFS_DIVL  = 8'h24;
  localparam logic [7:0] OFS_RDB   = 8'h28;
  // field positions
  localparam int GIC_GLOBAL = 7;
  localparam int GIC_PERIPH = 6;
  localparam int FLG_RX     = 5;
  localparam int FLG_TX     = 4;
  localparam int RCS_PORT   = 7;
  localparam int RCS_RX9    = 6;
  localparam int RCS_CONTINUOUS_RECEIVE_ENABLE   = 4;
  localparam int RCS_ADDRESS_DETECT_ENABLE  = 3;
  localparam int RCS_FRAMING_ERROR   = 2;
  localparam int RCS_OVERRUN_ERROR   = 1;
  localparam int RCS_RX_NINTH_BIT   = 0;
  localparam int TXS_TX9    = 6;
  localparam int TXS_TRANSMIT_ENABLE   = 5;
  localparam int TXS_SYNC   = 4;
  localparam int TXS_BAUD_HIGH_SPEED   = 2;
  localparam int TXS_SHIFTER_EMPTY   = 1;
  localparam int TXS_TX_NINTH_BIT   = 0;
  localparam int BLC_RXINV  = 5;
  localparam int BLC_TXINV  = 4;
  localparam int BLC_WIDE   = 3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing
  localparam logic [3:0] OS_LAST    = 4'hf;
  localparam logic [3:0] OS_MID     = 4'h7;
  localparam logic [1:0] PRE_LAST   = 2'h3;
  localparam logic [3:0] TX_BITS_8  = 4'ha;
  localparam logic [3:0] TX_BITS_9  = 4'hb;
  localparam logic [3:0] RX_LAST_8  = 4'h7;
  localparam logic [3:0] RX_LAST_9  = 4'h8;
  localparam logic [1:0] RX_DEPTH   = 2'h2;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;
endpackage

// *** ast_serial_top.sv ***
// asynchronous serial transceiver: baud generator, transmitter, receiver
// assumes a classic wishbone master on mclk and an rx pin from another domain
`timescale 1ns/1ps

// Notes on behaviour
// - runs only with clocked-mode select clear; start, 8 or 9 data, stop
// - lsb first both ways; shared baud, separate nine-bit and invert selects, independent paths
// - oversample tick is x16 bit rate; x64 divider when both speed bits clear
// - no hardware parity; ninth bit carries it if software wants
// - tx pin inverted by tx_invert, rx pin inverted by rx_invert
// - shifter reloads only after stop bit, at once if buffer holds data
// - buffer to shifter move takes one cycle, then buffer empty; flag set two cycles after that
// - tx empty flag needs transmit_enable, not writable, cleared by a buffer write or by clearing transmit_enable
// - tx empty flag follows a buffer write in the second cycle after
// - read-only shifter_empty status, no interrupt path
// - setting transmit_enable sets the tx empty flag
// - writing the holding buffer after enabling starts a character
// - ninth tx bit taken from tx_ninth_bit when tx_ninth_enable is set
// - receiver samples at x16 and shifts data at the bit rate
// - receiver runs under continuous receive; rx ready flag and irq request
// - receive status shows head ninth bit and errors before data is read
// - clearing continuous receive clears the latched overrun error
// - overrun set when a third character ends with two unread
// - with ninth bit and address detect, only address characters are kept
// - irq out needs global and peripheral gates plus the own enable
// - unimplemented bits read zero
module ast_serial_top #(
  parameter int ADR_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // serial pins
  input  wire logic              rx_pin,
  output logic                   tx_pin,
  // interrupt request to the processor
  output logic                   cpu_irq
);

  if (ADR_W != 8) begin : g_chk
    $error("ast_serial_top supports ADR_W of 8 only");
  end

  // bus decode
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] adr;
  logic [7:0] wbyte;
  assign acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = acc & wb_we_i & wb_sel_i[0];
  assign rd    = acc & ~wb_we_i;
  assign adr   = wb_adr_i;
  assign wbyte = wb_dat_i[7:0];

  // control registers
  logic       gie_r, peripheral_irq_gate_r, rx_irq_enable_r, tx_irq_enable_r, rx_irq_priority_r, txip_r;
  logic       port_enable_r, rx9_r, continuous_receive_enable_r, address_detect_enable_r;
  logic       tx9_r, transmit_enable_r, sync_r, baud_high_speed_r, tx_ninth_bit_r;
  logic       rxinv_r, txinv_r, wide_r;
  logic [7:0] divh_r, divl_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gie_r   <= 1'b0;
      peripheral_irq_gate_r  <= 1'b0;
      rx_irq_enable_r  <= 1'b0;
      tx_irq_enable_r  <= 1'b0;
      rx_irq_priority_r  <= 1'b0;
      txip_r  <= 1'b0;
      port_enable_r  <= 1'b0;
      rx9_r   <= 1'b0;
      continuous_receive_enable_r  <= 1'b0;
      address_detect_enable_r <= 1'b0;
      tx9_r   <= 1'b0;
      transmit_enable_r  <= 1'b0;
      sync_r  <= 1'b0;
      baud_high_speed_r  <= 1'b0;
      tx_ninth_bit_r  <= 1'b0;
      rxinv_r <= 1'b0;
      txinv_r <= 1'b0;
      wide_r  <= 1'b0;
      divh_r  <= ast_pkg::RST_BYTE;
      divl_r  <= ast_pkg::RST_BYTE;
    end else if (wr) begin
      case (adr)
        ast_pkg::OFS_GIC: begin
          gie_r  <= wbyte[ast_pkg::GIC_GLOBAL];
          peripheral_irq_gate_r <= wbyte[ast_pkg::GIC_PERIPH];
        end
        ast_pkg::OFS_ENAB: begin
          rx_irq_enable_r <= wbyte[ast_pkg::FLG_RX];
          tx_irq_enable_r <= wbyte[ast_pkg::FLG_TX];
        end
        ast_pkg::OFS_PRIO: begin
          rx_irq_priority_r <= wbyte[ast_pkg::FLG_RX];
          txip_r <= wbyte[ast_pkg::FLG_TX];
        end
        ast_pkg::OFS_RCS: begin
          port_enable_r  <= wbyte[ast_pkg::RCS_PORT];
          rx9_r   <= wbyte[ast_pkg::RCS_RX9];
          continuous_receive_enable_r  <= wbyte[ast_pkg::RCS_CONTINUOUS_RECEIVE_ENABLE];
          address_detect_enable_r <= wbyte[ast_pkg::RCS_ADDRESS_DETECT_ENABLE];
        end
        ast_pkg::OFS_TXS: begin
          tx9_r  <= wbyte[ast_pkg::TXS_TX9];
          transmit_enable_r <= wbyte[ast_pkg::TXS_TRANSMIT_ENABLE];
          sync_r <= wbyte[ast_pkg::TXS_SYNC];
          baud_high_speed_r <= wbyte[ast_pkg::TXS_BAUD_HIGH_SPEED];
          tx_ninth_bit_r <= wbyte[ast_pkg::TXS_TX_NINTH_BIT];
        end
        ast_pkg::OFS_BLC: begin
          rxinv_r <= wbyte[ast_pkg::BLC_RXINV];
          txinv_r <= wbyte[ast_pkg::BLC_TXINV];
          wide_r  <= wbyte[ast_pkg::BLC_WIDE];
        end
        ast_pkg::OFS_DIVH: divh_r <= wbyte;
        ast_pkg::OFS_DIVL: divl_r <= wbyte;
        default: ;
      endcase
    end
  end

  // baud generator
  logic [15:0] brg_cnt_r;
  logic [15:0] brg_div;
  logic [1:0]  pre_r;
  logic        brg_tick;
  logic        mult64;
  logic        os_tick;
  assign brg_div  = wide_r ? {divh_r, divl_r} : {8'h00, divl_r};
  assign brg_tick = (brg_cnt_r == 16'h0000);
  assign mult64   = ~baud_high_speed_r & ~wide_r;
  assign os_tick  = brg_tick & (~mult64 | (pre_r == ast_pkg::PRE_LAST));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      brg_cnt_r <= 16'h0000;
      pre_r     <= 2'h0;
    end else if (brg_tick) begin
      brg_cnt_r <= brg_div;
      pre_r     <= pre_r + 2'h1;
    end else begin
      brg_cnt_r <= brg_cnt_r - 16'h0001;
    end
  end

  // transmitter
  logic        run_tx;
  logic        thb_wr;
  logic        tx_load;
  logic [7:0]  hold_r;
  logic        hold9_r;
  logic        hold_full_r;
  logic [10:0] tsr_r;
  logic [3:0]  tx_left_r;
  logic [3:0]  tx_os_r;
  logic        tsr_empty_r;
  logic        tx_buffer_empty_flag_pipe_r;
  logic        tx_buffer_empty_flag_r;
  assign run_tx  = port_enable_r & transmit_enable_r & ~sync_r;
  assign thb_wr  = wr & (adr == ast_pkg::OFS_THB);
  assign tx_load = run_tx & hold_full_r & tsr_empty_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_r      <= ast_pkg::RST_BYTE;
      hold9_r     <= 1'b0;
      hold_full_r <= 1'b0;
    end else begin
      if (thb_wr) begin
        hold_r  <= wbyte;
        hold9_r <= tx_ninth_bit_r;
      end
      hold_full_r <= thb_wr | (hold_full_r & ~tx_load);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tsr_r       <= 11'h7ff;
      tx_left_r   <= 4'h0;
      tx_os_r     <= 4'h0;
      tsr_empty_r <= 1'b1;
    end else if (!run_tx) begin
      tsr_empty_r <= 1'b1;
    end else if (tx_load) begin
      // stop, ninth or stop, data, start; shifted out from bit 0
      tsr_r       <= {1'b1, (tx9_r ? hold9_r : 1'b1), hold_r, 1'b0};
      tx_left_r   <= tx9_r ? ast_pkg::TX_BITS_9 : ast_pkg::TX_BITS_8;
      tx_os_r     <= 4'h0;
      tsr_empty_r <= 1'b0;
    end else if (!tsr_empty_r && os_tick) begin
      tx_os_r <= tx_os_r + 4'h1;
      if (tx_os_r == ast_pkg::OS_LAST) begin
        tsr_r     <= {1'b1, tsr_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
        if (tx_left_r == 4'h1) begin
          tsr_empty_r <= 1'b1;
        end
      end
    end
  end

  // flag lags the buffer state by two cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buffer_empty_flag_pipe_r <= 1'b0;
      tx_buffer_empty_flag_r      <= 1'b0;
    end else begin
      tx_buffer_empty_flag_pipe_r <= transmit_enable_r & ~hold_full_r;
      tx_buffer_empty_flag_r      <= tx_buffer_empty_flag_pipe_r;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= ((tsr_empty_r | ~port_enable_r) ? 1'b1 : tsr_r[0]) ^ txinv_r;
    end
  end

  // receiver
  logic                   rx_s1_r, rx_s2_r;
  logic                   rx_line;
  logic                   run_rx;
  ast_pkg::ast_rx_state_t rx_st_r;
  logic [3:0]             rx_os_r;
  logic [3:0]             rx_bit_r;
  logic [8:0]             rx_sh_r;
  logic                   rx_done_r;
  logic                   rx_framing_error_r;
  assign rx_line = rx_s2_r ^ rxinv_r;
  assign run_rx  = port_enable_r & continuous_receive_enable_r & ~sync_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_r   <= ast_pkg::RX_IDLE;
      rx_os_r   <= 4'h0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 9'h000;
      rx_done_r <= 1'b0;
      rx_framing_error_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (!run_rx) begin
        rx_st_r <= ast_pkg::RX_IDLE;
      end else if (os_tick) begin
        rx_os_r <= rx_os_r + 4'h1;
        case (rx_st_r)
          ast_pkg::RX_IDLE: begin
            rx_os_r <= 4'h0;
            if (!rx_line) begin
              rx_st_r <= ast_pkg::RX_START;
            end
          end
          ast_pkg::RX_START: begin
            if (rx_os_r == ast_pkg::OS_MID) begin
              rx_os_r  <= 4'h0;
              rx_bit_r <= 4'h0;
              rx_st_r  <= rx_line ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
            end
          end
          ast_pkg::RX_DATA: begin
            if (rx_os_r == ast_pkg::OS_LAST) begin
              rx_sh_r  <= {rx_line, rx_sh_r[8:1]};
              rx_bit_r <= rx_bit_r + 4'h1;
              if (rx_bit_r == (rx9_r ? ast_pkg::RX_LAST_9 : ast_pkg::RX_LAST_8)) begin
                rx_st_r <= ast_pkg::RX_STOP;
              end
            end
          end
          ast_pkg::RX_STOP: begin
            if (rx_os_r == ast_pkg::OS_LAST) begin
              rx_done_r <= 1'b1;
              rx_framing_error_r <= ~rx_line;
              rx_st_r   <= ast_pkg::RX_IDLE;
            end
          end
          default: rx_st_r <= ast_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // two-entry receive buffer of {framing_error, ninth, data}
  logic [9:0] rx_mem [0:1];
  logic       rx_wp_r, rx_rp_r;
  logic [1:0] rx_cnt_r;
  logic       overrun_error_r;
  logic [7:0] rx_data;
  logic       rx_ninth;
  logic       addr_ok;
  logic       rx_accept;
  logic       rx_push;
  logic       rx_pop;
  logic [9:0] rx_head;
  assign rx_data   = rx9_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_ninth  = rx9_r & rx_sh_r[8];
  assign addr_ok   = ~(rx9_r & address_detect_enable_r) | rx_ninth;
  assign rx_accept = rx_done_r & addr_ok & ~overrun_error_r;
  assign rx_push   = rx_accept & (rx_cnt_r != ast_pkg::RX_DEPTH);
  assign rx_pop    = rd & (adr == ast_pkg::OFS_RDB) & (rx_cnt_r != 2'h0);
  assign rx_head   = (rx_cnt_r != 2'h0) ? rx_mem[rx_rp_r] : 10'h000;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_mem[0] <= 10'h000;
      rx_mem[1] <= 10'h000;
      rx_wp_r   <= 1'b0;
      rx_rp_r   <= 1'b0;
      rx_cnt_r  <= 2'h0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_r] <= {rx_framing_error_r, rx_ninth, rx_data};
        rx_wp_r         <= ~rx_wp_r;
      end
      if (rx_pop) begin
        rx_rp_r <= ~rx_rp_r;
      end
      rx_cnt_r <= rx_cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_error_r <= 1'b0;
    end else if (rx_accept && rx_cnt_r == ast_pkg::RX_DEPTH) begin
      overrun_error_r <= 1'b1;
    end else if (!continuous_receive_enable_r) begin
      overrun_error_r <= 1'b0;
    end
  end

  // read mux
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    case (adr)
      ast_pkg::OFS_GIC: begin
        rdata_nxt[ast_pkg::GIC_GLOBAL] = gie_r;
        rdata_nxt[ast_pkg::GIC_PERIPH] = peripheral_irq_gate_r;
      end
      ast_pkg::OFS_FLAGS: begin
        rdata_nxt[ast_pkg::FLG_RX] = (rx_cnt_r != 2'h0);
        rdata_nxt[ast_pkg::FLG_TX] = tx_buffer_empty_flag_r;
      end
      ast_pkg::OFS_ENAB: begin
        rdata_nxt[ast_pkg::FLG_RX] = rx_irq_enable_r;
        rdata_nxt[ast_pkg::FLG_TX] = tx_irq_enable_r;
      end
      ast_pkg::OFS_PRIO: begin
        rdata_nxt[ast_pkg::FLG_RX] = rx_irq_priority_r;
        rdata_nxt[ast_pkg::FLG_TX] = txip_r;
      end
      ast_pkg::OFS_RCS: begin
        rdata_nxt[ast_pkg::RCS_PORT]  = port_enable_r;
        rdata_nxt[ast_pkg::RCS_RX9]   = rx9_r;
        rdata_nxt[ast_pkg::RCS_CONTINUOUS_RECEIVE_ENABLE]  = continuous_receive_enable_r;
        rdata_nxt[ast_pkg::RCS_ADDRESS_DETECT_ENABLE] = address_detect_enable_r;
        rdata_nxt[ast_pkg::RCS_FRAMING_ERROR]  = rx_head[9];
        rdata_nxt[ast_pkg::RCS_OVERRUN_ERROR]  = overrun_error_r;
        rdata_nxt[ast_pkg::RCS_RX_NINTH_BIT]  = rx_head[8];
      end
      ast_pkg::OFS_THB: rdata_nxt = hold_r;
      ast_pkg::OFS_TXS: begin
        rdata_nxt[ast_pkg::TXS_TX9]  = tx9_r;
        rdata_nxt[ast_pkg::TXS_TRANSMIT_ENABLE] = transmit_enable_r;
        rdata_nxt[ast_pkg::TXS_SYNC] = sync_r;
        rdata_nxt[ast_pkg::TXS_BAUD_HIGH_SPEED] = baud_high_speed_r;
        rdata_nxt[ast_pkg::TXS_SHIFTER_EMPTY] = tsr_empty_r;
        rdata_nxt[ast_pkg::TXS_TX_NINTH_BIT] = tx_ninth_bit_r;
      end
      ast_pkg::OFS_BLC: begin
        rdata_nxt[ast_pkg::BLC_RXINV] = rxinv_r;
        rdata_nxt[ast_pkg::BLC_TXINV] = txinv_r;
        rdata_nxt[ast_pkg::BLC_WIDE]  = wide_r;
      end
      ast_pkg::OFS_DIVH: rdata_nxt = divh_r;
      ast_pkg::OFS_DIVL: rdata_nxt = divl_r;
      ast_pkg::OFS_RDB:  rdata_nxt = rx_head[7:0];
      default:           rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rd ? {24'h00_0000, rdata_nxt} : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= gie_r & peripheral_irq_gate_r & (((rx_cnt_r != 2'h0) & rx_irq_enable_r) | (tx_buffer_empty_flag_r & tx_irq_enable_r));
    end
  end

endmodule

// *** ast_serial_assertions.sv ***
// checker: bus answers, read-back zeros and irq gating at the top ports
// assumes classic wishbone masters and the package register map
`timescale 1ns/1ps
module ast_serial_assertions #(
  parameter int ADR_W = 8
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             arst_n,
  // bus
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // irq
  input wire logic             cpu_irq
);
  logic       take;
  logic [7:0] adr_q;
  logic [7:0] gic_q;
  logic [7:0] en_q;
  logic [7:0] mask;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // last taken address
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      adr_q <= 8'h00;
    end else if (take) begin
      adr_q <= wb_adr_i[7:0];
    end
  end
  // shadow of gate and enable registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gic_q <= 8'h00;
      en_q  <= 8'h00;
    end else if (take & wb_we_i & wb_sel_i[0]) begin
      if (wb_adr_i[7:0] == ast_pkg::OFS_GIC) begin
        gic_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i[7:0] == ast_pkg::OFS_ENAB) begin
        en_q <= wb_dat_i[7:0];
      end
    end
  end
  // bits that must read zero
  always_comb begin
    case (adr_q)
      ast_pkg::OFS_GIC:  mask = 8'h3f;
      ast_pkg::OFS_FLAGS,
      ast_pkg::OFS_ENAB,
      ast_pkg::OFS_PRIO: mask = 8'hcf;
      ast_pkg::OFS_RCS:  mask = 8'h20;
      ast_pkg::OFS_TXS:  mask = 8'h88;
      ast_pkg::OFS_BLC:  mask = 8'hc7;
      default:           mask = 8'h00;
    endcase
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_ack_after_take: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(take))
    else $error("ack without a request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_unimpl_zero: assert property (wb_ack_o && !$past(wb_we_i)
    |-> (wb_dat_o[7:0] & mask) == 8'h00) else $error("unimplemented bit set");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && adr_q > ast_pkg::OFS_RDB
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_irq_gated: assert property (cpu_irq
    |-> $past(gic_q[7] & gic_q[6] & (en_q[5] | en_q[4]))) else $error("irq not gated");
endmodule

bind ast_serial_top ast_serial_assertions #(.ADR_W(ADR_W)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_irq(cpu_irq));

// *** ast_serial_remote.sv ***
// remote serial node: drives the receive pin, decodes the transmit pin
// assumes an idle-high line and a bit time in mclk cycles set by the bench
`timescale 1ns/1ps
module ast_serial_remote (
  // clock
  input  wire logic       mclk,
  // line setup
  input  wire logic [7:0] bit_cyc,
  input  wire logic       nine,
  input  wire logic       tx_inv,
  input  wire logic       rx_inv,
  input  wire logic       listen,
  // pins
  input  wire logic       tx_pin,
  output logic            rx_pin
);
  logic       line_r;
  logic [8:0] d;
  logic [9:0] fr_q[$];
  assign rx_pin = line_r ^ rx_inv;
  initial line_r = 1'b1;
  // one frame, lsb first, then one idle bit
  task automatic send(input logic [8:0] v, input logic stop);
    line_r <= 1'b0;
    repeat (bit_cyc) @(posedge mclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      line_r <= v[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    line_r <= stop;
    repeat (bit_cyc) @(posedge mclk);
    line_r <= 1'b1;
    repeat (bit_cyc) @(posedge mclk);
  endtask
  // frames seen on the transmit pin, sampled at bit centres
  initial begin
    forever begin
      @(posedge mclk);
      if (listen && (tx_pin ^ tx_inv) === 1'b0) begin
        repeat (bit_cyc / 2) @(posedge mclk);
        d = 9'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (bit_cyc) @(posedge mclk);
          d[i] = tx_pin ^ tx_inv;
        end
        repeat (bit_cyc) @(posedge mclk);
        fr_q.push_back({tx_pin ^ tx_inv, d});
      end
    end
  end
endmodule

// *** ast_serial_tb_top.sv ***
// bench for the serial transceiver with a remote node on its pins
// assumes the package map; divisor 1 with high speed gives 32 mclk a bit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module ast_serial_tb_top;
  logic        mclk, arst_n, cyc, stb, we, ack, rxp, txp, irq;
  logic        txi, rxi, lst, nine;
  logic [7:0]  adr, rd, bc;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          n_errors, tests_run;
  ast_serial_top u_dut (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_pin(rxp), .tx_pin(txp), .cpu_irq(irq));
  ast_serial_remote u_rem (.mclk(mclk), .bit_cyc(bc), .nine(nine), .tx_inv(txi),
    .rx_inv(rxi), .listen(lst), .tx_pin(txp), .rx_pin(rxp));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dv);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, dv};
    @(posedge mclk);
    while (ack !== 1'b1 && t < 50) begin
      @(posedge mclk);
      t++;
    end
    `CHK("ack", 1'b1, ack)
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    wb(1'b1, a, dv);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), e, rd)
  endtask
  task automatic frame(input logic [9:0] e);
    int t;
    logic [9:0] f;
    t = 0;
    f = 10'h000;
    while (u_rem.fr_q.size() == 0 && t < 2000) begin
      @(posedge mclk);
      t++;
    end
    if (t < 2000) f = u_rem.fr_q.pop_front();
    `CHK("frame", e, f)
  endtask
  task automatic t_reset();
    rc(ast_pkg::OFS_TXS, 8'h02);
    rc(8'h30, 8'h00);
    wr(ast_pkg::OFS_BLC, 8'hff);
    rc(ast_pkg::OFS_BLC, 8'h38);
    wr(ast_pkg::OFS_BLC, 8'h00);
    // listener starts only once the tx pin idles high again
    lst = 1'b1;
    wr(ast_pkg::OFS_DIVL, 8'h01);
    wr(ast_pkg::OFS_TXS, 8'h04);
    wr(ast_pkg::OFS_RCS, 8'h80);
    rc(ast_pkg::OFS_FLAGS, 8'h00);
  endtask
  task automatic t_tx();
    wr(ast_pkg::OFS_TXS, 8'h34);
    rc(ast_pkg::OFS_FLAGS, 8'h10);
    wr(ast_pkg::OFS_FLAGS, 8'h00);
    rc(ast_pkg::OFS_FLAGS, 8'h10);
    wr(ast_pkg::OFS_THB, 8'ha5);
    rc(ast_pkg::OFS_TXS, 8'h36);
    wr(ast_pkg::OFS_TXS, 8'h24);
    wr(ast_pkg::OFS_THB, 8'h3c);
    rc(ast_pkg::OFS_FLAGS, 8'h00);
    rc(ast_pkg::OFS_TXS, 8'h24);
    frame(10'h2a5);
    frame(10'h23c);
    rc(ast_pkg::OFS_FLAGS, 8'h10);
    repeat (32) @(posedge mclk);
    rc(ast_pkg::OFS_TXS, 8'h26);
    nine = 1'b1;
    wr(ast_pkg::OFS_TXS, 8'h65);
    wr(ast_pkg::OFS_THB, 8'h5a);
    frame(10'h35a);
    nine = 1'b0;
    wr(ast_pkg::OFS_TXS, 8'h24);
    lst = 1'b0;
    wr(ast_pkg::OFS_BLC, 8'h10);
    txi = 1'b1;
    lst = 1'b1;
    `CHK("idle", 1'b0, txp)
    wr(ast_pkg::OFS_THB, 8'hc3);
    frame(10'h2c3);
    lst = 1'b0;
    wr(ast_pkg::OFS_BLC, 8'h00);
    txi = 1'b0;
    lst = 1'b1;
  endtask
  task automatic t_rx();
    wr(ast_pkg::OFS_RCS, 8'h90);
    u_rem.send(9'h03c, 1'b1);
    rc(ast_pkg::OFS_FLAGS, 8'h30);
    rc(ast_pkg::OFS_RCS, 8'h90);
    rc(ast_pkg::OFS_RDB, 8'h3c);
    u_rem.send(9'h081, 1'b0);
    wr(ast_pkg::OFS_RCS, 8'h80);
    wr(ast_pkg::OFS_RCS, 8'h90);
    rc(ast_pkg::OFS_RCS, 8'h94);
    rc(ast_pkg::OFS_RDB, 8'h81);
    u_rem.send(9'h011, 1'b1);
    u_rem.send(9'h022, 1'b1);
    u_rem.send(9'h033, 1'b1);
    rc(ast_pkg::OFS_RDB, 8'h11);
    u_rem.send(9'h044, 1'b1);
    rc(ast_pkg::OFS_RDB, 8'h22);
    rc(ast_pkg::OFS_RCS, 8'h92);
    wr(ast_pkg::OFS_RCS, 8'h80);
    rc(ast_pkg::OFS_RCS, 8'h80);
  endtask
  task automatic t_addr();
    nine = 1'b1;
    wr(ast_pkg::OFS_RCS, 8'hd8);
    u_rem.send(9'h055, 1'b1);
    rc(ast_pkg::OFS_FLAGS, 8'h10);
    u_rem.send(9'h1a7, 1'b1);
    rc(ast_pkg::OFS_RCS, 8'hd9);
    rc(ast_pkg::OFS_RDB, 8'ha7);
    wr(ast_pkg::OFS_RCS, 8'hd0);
    u_rem.send(9'h066, 1'b1);
    rc(ast_pkg::OFS_RDB, 8'h66);
    nine = 1'b0;
    wr(ast_pkg::OFS_RCS, 8'h80);
    wr(ast_pkg::OFS_BLC, 8'h20);
    rxi = 1'b1;
    wr(ast_pkg::OFS_RCS, 8'h90);
    u_rem.send(9'h05e, 1'b1);
    rc(ast_pkg::OFS_RDB, 8'h5e);
    wr(ast_pkg::OFS_RCS, 8'h80);
    wr(ast_pkg::OFS_BLC, 8'h00);
    rxi = 1'b0;
  endtask
  task automatic t_baud();
    bc = 8'd64;
    wr(ast_pkg::OFS_TXS, 8'h20);
    wr(ast_pkg::OFS_DIVL, 8'h00);
    wr(ast_pkg::OFS_THB, 8'h96);
    frame(10'h296);
    wr(ast_pkg::OFS_BLC, 8'h08);
    wr(ast_pkg::OFS_DIVL, 8'h03);
    wr(ast_pkg::OFS_THB, 8'h69);
    frame(10'h269);
    wr(ast_pkg::OFS_RCS, 8'h90);
    u_rem.send(9'h0e1, 1'b1);
    rc(ast_pkg::OFS_RDB, 8'he1);
  endtask
  task automatic t_irq();
    wr(ast_pkg::OFS_ENAB, 8'h10);
    `CHK("irq", 1'b0, irq)
    wr(ast_pkg::OFS_GIC, 8'hc0);
    `CHK("irq", 1'b1, irq)
    wr(ast_pkg::OFS_GIC, 8'h80);
    `CHK("irq", 1'b0, irq)
    wr(ast_pkg::OFS_GIC, 8'hc0);
    wr(ast_pkg::OFS_ENAB, 8'h20);
    `CHK("irq", 1'b0, irq)
    u_rem.send(9'h0f0, 1'b1);
    `CHK("irq", 1'b1, irq)
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // about eight times the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    bc = 8'd32;
    {txi, rxi, lst, nine} = 4'h0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_tx();
    t_rx();
    t_addr();
    t_baud();
    t_irq();
    tally_and_finish();
  end
endmodule
